//--- common/pau_consts.vh
// shared constants for the process alarm unit: timing, widths, register map, codes
`ifndef PAU_CONSTS_VH
`define PAU_CONSTS_VH
// clock period and the one-second timer tick, both in ns
`define PAU_CLK_NS 50
`define PAU_SECOND_NS 1000000000
// prescaler counter width, enough for 20,000,000 cycles
`define PAU_PRE_W 25
// number of alarm channels
`define PAU_NCH 2
// signed display-count value width, -1999 to 9999
`define PAU_VW 15
// timer setting width and ceiling, 0 to 6500 s
`define PAU_TW 13
`define PAU_TMAX 13'h1964
`define PAU_TZERO 13'h0000
`define PAU_TONE 13'h0001
// alarm function codes
`define PAU_DISABLED_FUNCTION 3'h0
`define PAU_SENSOR_FAULT_FUNCTION 3'h1
`define PAU_LOW_FUNCTION 3'h2
`define PAU_HIGH_FUNCTION 3'h3
`define PAU_DIFFERENTIAL_LOW_FUNCTION 3'h4
`define PAU_DIFFERENTIAL_HIGH_FUNCTION 3'h5
`define PAU_BAND_FUNCTION 3'h6
// configuration word fields
`define PAU_CFG_W 5
`define PAU_CFG_FN_MSB 2
`define PAU_CFG_BLK_BIT 4
// address layout: byte offset 0x00 for channel one, 0x20 for channel two
`define PAU_CH_BIT 5
`define PAU_WORD_MSB 4
`define PAU_WORD_LSB 2
`define PAU_IDX_CFG 3'h0
`define PAU_IDX_REF 3'h1
`define PAU_IDX_DEV 3'h2
`define PAU_IDX_TFIRST 3'h3
`define PAU_IDX_TSECOND 3'h4
`define PAU_IDX_STAT 3'h5
// reset values
`define PAU_CFG_RST 5'h00
`define PAU_VAL_RST 15'h0000
`define PAU_DATA_ZERO 32'h00000000
`endif

//--- rtl/pau_second.v
// one-second tick prescaler that restarts whenever its run input drops
`include "pau_consts.vh"
module pau_second #(
  parameter TICK_CYCLES = `PAU_SECOND_NS / `PAU_CLK_NS
)(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire run,
  output reg tick
);

  // last count of one second, cut to the counter width
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // cycle counter within the current second
  reg [`PAU_PRE_W-1:0] count;

  // counting restarts from zero on each run, so every interval is a full second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= {`PAU_PRE_W{1'b0}};
      tick <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        // idle: hold at zero, no tick
        count <= {`PAU_PRE_W{1'b0}};
        tick <= 1'b0;
      end
      else if (count == TICK_LAST[`PAU_PRE_W-1:0])
      begin
        count <= {`PAU_PRE_W{1'b0}};
        tick <= 1'b1;
      end
      else
      begin
        count <= count + {{(`PAU_PRE_W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end
  end

endmodule // pau_second

//--- rtl/pau_top.v
// process alarm unit: apb registers, two alarm channels with relay timing
//
// Local design decisions: register access over APB and the register offsets.
`include "pau_consts.vh"

// Overview of operation
// - two channels, each relay plus status LED
// - seven functions; disabled never alarms
// - sensor-break alarms while input fault flag set
// - low below setpoint, high above setpoint
// - differential uses reference plus signed deviation
// - band, positive deviation: alarm outside band
// - band, negative deviation: alarm inside band
// - diff-low below ref-dev, diff-high above ref+dev
// - two timers per channel, 0 to 6500 s
// - both timers zero: relay follows condition
// - only second timer set: delayed relay
// - only first timer set: single pulse
// - both timers set: relay oscillates
// - LED shows condition regardless of timing
// - blocking hides condition present at power-up
// - blocked until clear then fresh alarm
// - blocking ignored for sensor-break function
// - re-evaluate every channel on each sample
// - values signed, range -1999 to 9999
module pau_top #(
  parameter TICK_CYCLES = `PAU_SECOND_NS / `PAU_CLK_NS
)(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pv_valid,
  input wire [`PAU_VW-1:0] pv_value,
  input wire pv_fault,
  output wire alarm_relay_first,
  output wire alarm_relay_second,
  output wire alarm_led_first,
  output wire alarm_led_second
);

  // relay timing states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FOLLOW = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_PULSE = 3'h3;
  localparam [2:0] ST_SPENT = 3'h4;
  localparam [2:0] ST_OSC_ON = 3'h5;
  localparam [2:0] ST_OSC_OFF = 3'h6;

  // word-aligned, within the two channel windows, index up to status
  function reg_hit;
    input [7:0] a;
    begin
      reg_hit = (a[1:0] == 2'h0) && (a[7:6] == 2'h0) &&
        (a[`PAU_WORD_MSB:`PAU_WORD_LSB] <= `PAU_IDX_STAT);
    end
  endfunction

  // saturate a written timer value at the ceiling
  function [`PAU_TW-1:0] clamp_time;
    input [31:0] w;
    begin
      if (w > {19'h00000, `PAU_TMAX})
        clamp_time = `PAU_TMAX;
      else
        clamp_time = w[`PAU_TW-1:0];
    end
  endfunction

  // raw alarm condition of one channel for the current sample
  function eval_alarm;
    input [2:0] fn;
    input [`PAU_VW-1:0] pv;
    input fault;
    input [`PAU_VW-1:0] ref_v;
    input [`PAU_VW-1:0] dev_v;
    reg signed [`PAU_VW+1:0] v;
    reg signed [`PAU_VW+1:0] s;
    reg signed [`PAU_VW+1:0] d;
    reg signed [`PAU_VW+1:0] lo;
    reg signed [`PAU_VW+1:0] hi;
    begin
      // two guard bits keep ref +/- dev from wrapping
      v = {{2{pv[`PAU_VW-1]}}, pv};
      s = {{2{ref_v[`PAU_VW-1]}}, ref_v};
      d = {{2{dev_v[`PAU_VW-1]}}, dev_v};
      lo = s - d;
      hi = s + d;
      case (fn)
        `PAU_SENSOR_FAULT_FUNCTION: eval_alarm = fault;
        `PAU_LOW_FUNCTION: eval_alarm = (v < s);
        `PAU_HIGH_FUNCTION: eval_alarm = (v > s);
        `PAU_DIFFERENTIAL_LOW_FUNCTION: eval_alarm = (v < lo);
        `PAU_DIFFERENTIAL_HIGH_FUNCTION: eval_alarm = (v > hi);
        `PAU_BAND_FUNCTION:
        begin
          if (!d[`PAU_VW+1])
            eval_alarm = (v < lo) || (v > hi);
          else
            eval_alarm = (v > hi) && (v < lo);
        end
        // disabled and the unused code never alarm
        default: eval_alarm = 1'b0;
      endcase
    end
  endfunction

  // per-channel configuration storage, addressed by channel index
  reg [`PAU_CFG_W-1:0] cfg [0:`PAU_NCH-1];
  reg [`PAU_VW-1:0] band_reference [0:`PAU_NCH-1];
  reg [`PAU_VW-1:0] deviation [0:`PAU_NCH-1];
  reg [`PAU_TW-1:0] first_timer_setting [0:`PAU_NCH-1];
  reg [`PAU_TW-1:0] second_timer_setting [0:`PAU_NCH-1];

  // per-channel status: blocked, relay, condition
  wire [2:0] stat_w [0:`PAU_NCH-1];
  wire [`PAU_NCH-1:0] relay_w;
  wire [`PAU_NCH-1:0] led_w;

  // address split
  wire ch_idx = paddr[`PAU_CH_BIT];
  wire [2:0] word = paddr[`PAU_WORD_MSB:`PAU_WORD_LSB];
  wire hit = reg_hit(paddr);
  wire setup = psel & ~penable;

  // write strobe: only at the completing access edge
  wire wr_go = psel & penable & pready & pwrite & reg_hit(paddr);

  // read data prepared during the setup cycle
  reg [31:0] next_rdata;
  integer i;

  // read multiplexer; bits above each field read as zero
  always @*
  begin
    next_rdata = `PAU_DATA_ZERO;
    case (word)
      `PAU_IDX_CFG: next_rdata[`PAU_CFG_W-1:0] = cfg[ch_idx];
      `PAU_IDX_REF: next_rdata[`PAU_VW-1:0] = band_reference[ch_idx];
      `PAU_IDX_DEV: next_rdata[`PAU_VW-1:0] = deviation[ch_idx];
      `PAU_IDX_TFIRST: next_rdata[`PAU_TW-1:0] = first_timer_setting[ch_idx];
      `PAU_IDX_TSECOND: next_rdata[`PAU_TW-1:0] = second_timer_setting[ch_idx];
      `PAU_IDX_STAT: next_rdata[2:0] = stat_w[ch_idx];
      default: next_rdata = `PAU_DATA_ZERO;
    endcase
    // unmapped addresses read zero
    if (!hit)
      next_rdata = `PAU_DATA_ZERO;
  end

  // apb handshake: one wait-free access, answer registered from setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PAU_DATA_ZERO;
    end
    else if (clk_en)
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      // data held outside a read so the bus sees no glitches
      if (setup & ~pwrite)
        prdata <= next_rdata;
    end
  end

  // register writes; writes to status or unmapped words are dropped
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < `PAU_NCH; i = i + 1)
      begin
        cfg[i] <= `PAU_CFG_RST;
        band_reference[i] <= `PAU_VAL_RST;
        deviation[i] <= `PAU_VAL_RST;
        first_timer_setting[i] <= `PAU_TZERO;
        second_timer_setting[i] <= `PAU_TZERO;
      end
    end
    else if (clk_en & wr_go)
    begin
      case (word)
        `PAU_IDX_CFG: cfg[ch_idx] <= pwdata[`PAU_CFG_W-1:0];
        `PAU_IDX_REF: band_reference[ch_idx] <= pwdata[`PAU_VW-1:0];
        `PAU_IDX_DEV: deviation[ch_idx] <= pwdata[`PAU_VW-1:0];
        `PAU_IDX_TFIRST: first_timer_setting[ch_idx] <= clamp_time(pwdata);
        `PAU_IDX_TSECOND: second_timer_setting[ch_idx] <= clamp_time(pwdata);
        default:
        begin
          // status is read-only
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PAU_NCH; g = g + 1)
    begin : chan
      // channel configuration view
      wire [2:0] fn = cfg[g][`PAU_CFG_FN_MSB:0];
      wire blk_en = cfg[g][`PAU_CFG_BLK_BIT];
      wire t1_zero = (first_timer_setting[g] == `PAU_TZERO);
      wire t2_zero = (second_timer_setting[g] == `PAU_TZERO);

      // raw condition from the present sample inputs
      wire raw = eval_alarm(fn, pv_value, pv_fault, band_reference[g], deviation[g]);

      // blocking only matters outside the sensor-break function
      wire blk_act = blk_en & (fn != `PAU_SENSOR_FAULT_FUNCTION);

      reg cond; // evaluated condition, drives the LED
      reg blocked; // set from power-up until a clear sample
      reg relay; // relay drive
      reg [2:0] state; // relay timing state
      reg [`PAU_TW-1:0] cnt; // seconds elapsed in the current phase
      reg [2:0] next_state;
      reg [`PAU_TW-1:0] next_cnt;
      reg next_relay;
      wire [`PAU_TW-1:0] cnt_up = cnt + `PAU_TONE;
      wire tick;

      // prescaler runs only in timed phases, so each phase starts clean
      wire timing = cond & ((state == ST_DELAY) | (state == ST_PULSE) |
        (state == ST_OSC_ON) | (state == ST_OSC_OFF));

      pau_second #(
        .TICK_CYCLES(TICK_CYCLES)
      ) u_second (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .run(timing),
        .tick(tick)
      );

      // condition is sampled only on a new measurement
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cond <= 1'b0;
          // power-up counts as blocked; only honoured if enabled
          blocked <= 1'b1;
        end
        else if (clk_en & pv_valid)
        begin
          // a clear sample lifts blocking for good
          if (!raw)
            blocked <= 1'b0;
          // uses the old blocked flag: a fresh alarm needs a prior clear
          cond <= raw & ~(blocked & blk_act);
        end
      end

      // relay timing: follow, delay, pulse or oscillate
      always @*
      begin
        next_state = state;
        next_cnt = cnt;
        next_relay = relay;
        if (!cond)
        begin
          // condition gone: restart timing, release relay
          next_state = ST_IDLE;
          next_cnt = `PAU_TZERO;
          next_relay = 1'b0;
        end
        else
        begin
          case (state)
            ST_IDLE:
            begin
              next_cnt = `PAU_TZERO;
              if (t1_zero & t2_zero)
              begin
                next_state = ST_FOLLOW;
                next_relay = 1'b1;
              end
              else if (t1_zero)
              begin
                next_state = ST_DELAY;
                next_relay = 1'b0;
              end
              else if (t2_zero)
              begin
                next_state = ST_PULSE;
                next_relay = 1'b1;
              end
              else
              begin
                next_state = ST_OSC_ON;
                next_relay = 1'b1;
              end
            end
            ST_FOLLOW: next_relay = 1'b1;
            ST_DELAY:
            begin
              // relay waits for the second timer to expire
              if (tick)
              begin
                if (cnt_up >= second_timer_setting[g])
                begin
                  next_state = ST_FOLLOW;
                  next_relay = 1'b1;
                  next_cnt = `PAU_TZERO;
                end
                else
                  next_cnt = cnt_up;
              end
            end
            ST_PULSE:
            begin
              // pulse length is the first timer
              if (tick)
              begin
                if (cnt_up >= first_timer_setting[g])
                begin
                  next_state = ST_SPENT;
                  next_relay = 1'b0;
                  next_cnt = `PAU_TZERO;
                end
                else
                  next_cnt = cnt_up;
              end
            end
            // one pulse per event: stay off until the condition clears
            ST_SPENT: next_relay = 1'b0;
            ST_OSC_ON:
            begin
              if (tick)
              begin
                if (cnt_up >= first_timer_setting[g])
                begin
                  next_state = ST_OSC_OFF;
                  next_relay = 1'b0;
                  next_cnt = `PAU_TZERO;
                end
                else
                  next_cnt = cnt_up;
              end
            end
            ST_OSC_OFF:
            begin
              if (tick)
              begin
                if (cnt_up >= second_timer_setting[g])
                begin
                  next_state = ST_OSC_ON;
                  next_relay = 1'b1;
                  next_cnt = `PAU_TZERO;
                end
                else
                  next_cnt = cnt_up;
              end
            end
            default:
            begin
              next_state = ST_IDLE;
              next_cnt = `PAU_TZERO;
              next_relay = 1'b0;
            end
          endcase
        end
      end

      // timing registers; relay lags the condition by one clock
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          state <= ST_IDLE;
          cnt <= `PAU_TZERO;
          relay <= 1'b0;
        end
        else if (clk_en)
        begin
          state <= next_state;
          cnt <= next_cnt;
          relay <= next_relay;
        end
      end

      // LED is the condition itself, not the timed relay
      assign led_w[g] = cond;
      assign relay_w[g] = relay;
      assign stat_w[g] = {blocked & blk_act, relay, cond};
    end
  endgenerate

  // channel outputs, each straight from its flop
  assign alarm_relay_first = relay_w[0];
  assign alarm_relay_second = relay_w[1];
  assign alarm_led_first = led_w[0];
  assign alarm_led_second = led_w[1];

endmodule // pau_top

//--- verif/pau_props.sv
// port-level checks for the alarm unit
module pau_props #(
  parameter TICK_CYCLES = 10
)(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire pv_valid,
  input wire alarm_relay_first,
  input wire alarm_relay_second,
  input wire alarm_led_first,
  input wire alarm_led_second
);
  timeunit 1ns;
  timeprecision 1ns;
  // setup cycle as the slave takes it
  wire setup = psel && !penable && clk_en;
  // mapped: aligned, within the two channel windows, word index five or less
  wire mapped = paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h5;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_next_a: assert property (setup |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready && clk_en |=> !pready)
    else $error("ready held past one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  misalign_err_a: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read not zero");
  led_on_sample_a: assert property (!(pv_valid && clk_en) |=> $stable({alarm_led_first, alarm_led_second}))
    else $error("status led moved without a sample");
  relay_one_idle_a: assert property (!alarm_led_first && clk_en |=> !alarm_relay_first)
    else $error("first relay on without condition");
  relay_two_idle_a: assert property (!alarm_led_second && clk_en |=> !alarm_relay_second)
    else $error("second relay on without condition");
  freeze_hold_a: assert property (!clk_en |=> $stable({alarm_relay_first,
      alarm_relay_second, alarm_led_first, alarm_led_second, pready, pslverr, prdata}))
    else $error("outputs moved while clock enable low");
endmodule // pau_props

bind pau_top pau_props #(.TICK_CYCLES(TICK_CYCLES)) u_pau_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pv_valid(pv_valid), .alarm_relay_first(alarm_relay_first),
  .alarm_relay_second(alarm_relay_second), .alarm_led_first(alarm_led_first),
  .alarm_led_second(alarm_led_second)
);

//--- verif/pau_front.sv
// measurement front end model: one-cycle sample strobes
`include "pau_consts.vh"
module pau_front (
  input wire pclk,
  input wire presetn,
  input wire req,
  input wire [`PAU_VW-1:0] req_value,
  input wire req_fault,
  output logic pv_valid,
  output logic [`PAU_VW-1:0] pv_value,
  output logic pv_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  // value lines mean something only in the strobe cycle; they churn
  // otherwise so a design that samples off the strobe sees garbage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pv_valid <= 1'b0;
      pv_value <= 15'h0000;
      pv_fault <= 1'b0;
    end
    else
    begin
      pv_valid <= req;
      pv_value <= req ? req_value : ~pv_value;
      pv_fault <= req ? req_fault : ~pv_fault;
    end
  end
endmodule // pau_front

//--- verif/pau_top_test.sv
// self-checking bench for the alarm unit
`include "pau_consts.vh"
module pau_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICKS = 10; // short second keeps timer runs brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic req = 1'b0;
  logic [`PAU_VW-1:0] req_value = 15'h0000;
  logic req_fault = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, pv_valid, pv_fault;
  wire [`PAU_VW-1:0] pv_value;
  wire rly1, rly2, alarm_led_first, alarm_led_second;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000B4E9;
  pau_top #(.TICK_CYCLES(TICKS)) u_pau_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pv_valid(pv_valid), .pv_value(pv_value), .pv_fault(pv_fault),
    .alarm_relay_first(rly1), .alarm_relay_second(rly2),
    .alarm_led_first(alarm_led_first), .alarm_led_second(alarm_led_second));
  pau_front u_pau_front (
    .pclk(pclk), .presetn(presetn), .req(req), .req_value(req_value),
    .req_fault(req_fault), .pv_valid(pv_valid), .pv_value(pv_value), .pv_fault(pv_fault));
  initial forever #25 pclk = ~pclk;
  // xorshift source, fixed start for repeatable runs
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected alarm condition, strict compares throughout
  function automatic logic cond(int fn, int pv, logic f, int r, int d);
    case (fn)
      1: return f;
      2: return pv < r;
      3: return pv > r;
      4: return pv < r - d;
      5: return pv > r + d;
      6: return d < 0 ? (pv > r + d && pv < r - d) : (pv < r - d || pv > r + d);
      default: return 1'b0;
    endcase
  endfunction
  // ideal relay-on cycles in a window, one cycle of lag
  function automatic int ideal_on(int t1, int t2, int w);
    int n;
    n = 0;
    for (int s = -1; s < w - 1; s++)
      if (s >= 0 && (t1 == 0 ? s >= t2 * TICKS : t2 == 0 ? s < t1 * TICKS :
          s % ((t1 + t2) * TICKS) < t1 * TICKS))
        n++;
    return n;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, pready);
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk("write error", 32'h0, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("read data", x, q);
    chk("read error", xe, e);
  endtask
  // strobe one sample; returns at the settled cycle after it is taken
  task automatic smp(input int v, input logic f);
    @(posedge pclk);
    req <= 1'b1;
    req_value <= v[`PAU_VW-1:0];
    req_fault <= f;
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic close_out();
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far above the roughly 1100 cycles needed
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    int fn, pv, r, d, hi, lit, t1, t2;
    logic c;
    logic [7:0] b;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h30, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    // power-up blocking on channel one; channel two is sensor-break, where blocking is ignored
    wr(8'h00, 32'h13);
    wr(8'h04, 100);
    wr(8'h20, 32'h11);
    smp(500, 1'b1);
    chk("led one blocked", 32'h0, alarm_led_first);
    chk("led two fault", 32'h1, alarm_led_second);
    rd(8'h14, 32'h4, 1'b0);
    smp(0, 1'b1);
    smp(500, 1'b0);
    chk("led one fresh", 32'h1, alarm_led_first);
    chk("led two clear", 32'h0, alarm_led_second);
    // every function, thresholds hit exactly and at random
    for (int i = 0; i < 42; i++)
    begin
      fn = i / 6;
      b = (i % 2) ? 8'h20 : 8'h00;
      r = int'(rnd() % 6000) - 1000;
      d = int'(rnd() % 1001) - 500;
      pv = (i % 6 == 0) ? r : (i % 6 == 1) ? r - d : (i % 6 == 2) ? r + d : int'(rnd() % 11999) - 1999;
      c = rnd() % 2;
      wr(b, fn);
      wr(b + 8'h04, r);
      wr(b + 8'h08, d);
      smp(pv, c);
      c = cond(fn, pv, c, r, d);
      chk("led", c, (i % 2) ? alarm_led_second : alarm_led_first);
      @(negedge pclk);
      chk("relay", c, (i % 2) ? rly2 : rly1);
      rd(b + 8'h14, {30'h0, c, c}, 1'b0);
    end
    wr(8'h10, 7000);
    rd(8'h10, 32'h00001964, 1'b0);
    // delayed, pulse and oscillator timing on channel one
    wr(8'h00, `PAU_HIGH_FUNCTION);
    wr(8'h04, 0);
    for (int m = 0; m < 3; m++)
    begin
      t1 = (m == 0) ? 0 : 1;
      t2 = (m == 1) ? 0 : 2;
      wr(8'h0C, t1);
      wr(8'h10, t2);
      smp(0, 1'b0);
      smp(50, 1'b0);
      hi = 0;
      lit = 0;
      for (int k = 0; k < 90; k++)
      begin
        hi += (rly1 === 1'b1);
        lit += (alarm_led_first === 1'b1);
        @(negedge pclk);
      end
      hi = hi - ideal_on(t1, t2, 90);
      chk("relay on time", 32'h1, hi >= -6 && hi <= 6);
      chk("led held", 32'h0000005A, lit);
    end
    // clock enable low: a sample offered then is lost and state holds
    @(posedge pclk);
    clk_en <= 1'b0;
    smp(0, 1'b0);
    chk("led frozen", 32'h1, alarm_led_first);
    @(posedge pclk);
    clk_en <= 1'b1;
    smp(0, 1'b0);
    @(negedge pclk);
    chk("relay released", 32'h0, rly1);
    close_out();
  end
endmodule // pau_top_test
